// >>> inc/adc_pin_regs.vh
// Purpose: addresses, field positions, reset values and timing counts
// Assumes: byte-wide cpu memory port, 100 MHz system clock
// Notes:   definitions only
`ifndef ADC_PIN_REGS_VH
`define ADC_PIN_REGS_VH

// ==========================================================
// register addresses
`define ADDR_RESULT_LOW      16'hFF06
`define ADDR_RESULT_HIGH     16'hFF07
`define ADDR_CHANNEL_SELECT  16'hFF8E
`define ADDR_PIN_CONFIG      16'hFF8F
`define ADDR_PORT_DIRECTION  16'hFF8F

// ==========================================================
// reset values
`define RST_RESULT_HIGH      8'h00
`define RST_RESULT_WORD      16'h0000
`define RST_CHANNEL_SELECT   8'h00
`define RST_PIN_CONFIG       8'h08
`define RST_PORT_DIRECTION   8'hFF

// ==========================================================
// field layout
`define CHANNEL_CODE_MSB     2
`define PIN_CODE_MSB         2
`define PIN_CONFIG_KEEP_MSB  3
`define DIR_FIXED_ONES       2'h3
`define DIR_MSB              5
`define NUM_PINS             6
`define LAST_VALID_CHANNEL   3'h5
`define LAST_VALID_PIN_CODE  3'h6
`define RESULT_BITS          10
`define RESULT_LOW_ZEROS     6

// ==========================================================
// timing: sample phase length
`define SAMPLE_TIME_NS       200
`define CLK_PERIOD_NS        10
`define SAMPLE_CYCLES        (`SAMPLE_TIME_NS / `CLK_PERIOD_NS)
// last value of the sample counter, sample cycles minus one
`define SAMPLE_LAST_COUNT    8'h13

`endif

// >>> rtl/sar_engine.v
// Purpose: successive approximation sequencer, one bit per clock
// Assumes: comparator answer valid in the same clock as the trial code
// Notes:   runs continuously while enabled, restart begins anew
`timescale 1ns/1ps
`default_nettype none
`include "adc_pin_regs.vh"

module sar_engine (
  input  wire       i_sys_clk,
  input  wire       i_reset,
  input  wire       i_run,
  input  wire       i_restart,
  input  wire       i_cmp_ge,
  output wire [9:0] o_trial_code,
  output wire       o_sampling,
  output reg        o_done,
  output reg  [9:0] o_sar_value
);

  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_SAMPLE = 2'h1;
  localparam [1:0] ST_CONV   = 2'h2;

  reg [1:0] state_q;
  reg [7:0] count_q;
  reg [9:0] sar_q;
  reg [9:0] bit_q;

  assign o_trial_code = sar_q | bit_q;
  assign o_sampling   = (state_q == ST_SAMPLE);

  // ==========================================================
  // sequencer
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_q     <= ST_IDLE;
      count_q     <= 8'h00;
      sar_q       <= 10'h000;
      bit_q       <= 10'h000;
      o_done      <= 1'b0;
      o_sar_value <= 10'h000;
    end else begin
      o_done <= 1'b0;
      if (!i_run) begin
        state_q <= ST_IDLE;
      end else if (i_restart) begin
        state_q <= ST_SAMPLE;
        count_q <= 8'h00;
      end else begin
        case (state_q)
          ST_IDLE: begin
            state_q <= ST_SAMPLE;
            count_q <= 8'h00;
          end
          ST_SAMPLE: begin
            if (count_q == `SAMPLE_LAST_COUNT) begin
              state_q <= ST_CONV;
              sar_q   <= 10'h000;
              bit_q   <= 10'h200;
            end else begin
              count_q <= count_q + 8'h01;
            end
          end
          ST_CONV: begin
            if (i_cmp_ge) begin
              sar_q <= sar_q | bit_q;
            end
            bit_q <= bit_q >> 1;
            if (bit_q == 10'h001) begin
              o_sar_value <= i_cmp_ge ? (sar_q | bit_q) : sar_q;
              o_done      <= 1'b1;
              state_q     <= ST_SAMPLE;
              count_q     <= 8'h00;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/adc_pin_control.v
// Purpose: converter result, channel select, pin config and direction
// Assumes: cpu byte port synchronous to i_sys_clk
// Notes:   pin config and direction share one address, split by i_port_sel
//
// Operation
// - 8-bit read-only result holds upper eight result bits, resets zero
// - channel codes 0..5 pick inputs 0..5, 6 and 7 prohibited
// - pin code n makes the n lowest pins digital, others prohibited
// - pin configuration register resets to 08H
// - segment selection forces segment output regardless of pin config
// - direction bit 0 enables output buffer, 1 selects input
// - direction resets to all ones, two top bits read one
// - analog input pin converted only when channel selects it
// - digital pin follows direction; analog output is prohibited
// - result read and select/config write insert a cpu wait cycle
// - select, config and direction take bit and byte writes
// - 16-bit word: high byte upper bits, low two on top, six zeros
// - every conversion end loads result from approximation register
// - channel write aborts conversion, restarts while still enabled
`timescale 1ns/1ps
`default_nettype none
`include "adc_pin_regs.vh"

module adc_pin_control (
  input  wire        i_sys_clk,
  input  wire        i_reset,
  input  wire [15:0] i_addr,
  input  wire        i_port_sel,
  input  wire        i_rd,
  input  wire        i_wr,
  input  wire [7:0]  i_wdata,
  input  wire [7:0]  i_wmask,
  input  wire        i_conversion_enable,
  input  wire        i_cmp_ge,
  input  wire [5:0]  i_segment_function_select,
  output reg  [7:0]  o_rdata,
  output wire        o_wait,
  output reg  [15:0] o_result_word,
  output reg  [7:0]  o_result_high_byte,
  output wire [9:0]  o_trial_code,
  output wire        o_sampling,
  output reg         o_conv_done,
  output reg  [5:0]  o_analog_mux_sel,
  output reg  [5:0]  o_analog_pins,
  output reg  [5:0]  o_port_out_en,
  output reg  [5:0]  o_port_in_en,
  output reg  [5:0]  o_segment_en,
  output reg         o_setting_prohibited
);

  // ==========================================================
  // helpers
  function [7:0] merge_bits;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] mask;
    begin
      merge_bits = (old_val & ~mask) | (new_val & mask);
    end
  endfunction

  // pins below code are digital
  function [5:0] digital_mask;
    input [2:0] code;
    begin
      case (code)
        3'h0:    digital_mask = 6'h00;
        3'h1:    digital_mask = 6'h01;
        3'h2:    digital_mask = 6'h03;
        3'h3:    digital_mask = 6'h07;
        3'h4:    digital_mask = 6'h0F;
        3'h5:    digital_mask = 6'h1F;
        3'h6:    digital_mask = 6'h3F;
        default: digital_mask = 6'h3F;
      endcase
    end
  endfunction

  function [5:0] channel_onehot;
    input [2:0] code;
    begin
      case (code)
        3'h0:    channel_onehot = 6'h01;
        3'h1:    channel_onehot = 6'h02;
        3'h2:    channel_onehot = 6'h04;
        3'h3:    channel_onehot = 6'h08;
        3'h4:    channel_onehot = 6'h10;
        3'h5:    channel_onehot = 6'h20;
        default: channel_onehot = 6'h00;
      endcase
    end
  endfunction

  // ==========================================================
  // address decode
  wire sel_res_lo = (i_addr == `ADDR_RESULT_LOW);
  wire sel_res_hi = (i_addr == `ADDR_RESULT_HIGH);
  wire sel_chan   = (i_addr == `ADDR_CHANNEL_SELECT);
  wire sel_cfg    = (i_addr == `ADDR_PIN_CONFIG) && !i_port_sel;
  wire sel_dir    = (i_addr == `ADDR_PORT_DIRECTION) && i_port_sel;

  wire wr_chan = i_wr && sel_chan;
  wire wr_cfg  = i_wr && sel_cfg;
  wire wr_dir  = i_wr && sel_dir;

  assign o_wait = (i_rd && (sel_res_lo || sel_res_hi)) ||
                  wr_chan || wr_cfg;

  // ==========================================================
  // software registers
  reg  [2:0] channel_code_q;
  reg  [3:0] pin_config_q;
  reg  [5:0] direction_q;

  wire [7:0] chan_rd = {5'h00, channel_code_q};
  wire [7:0] cfg_rd  = {4'h0, pin_config_q};
  wire [7:0] dir_rd  = {`DIR_FIXED_ONES, direction_q};
  wire [7:0] chan_new = merge_bits(chan_rd, i_wdata, i_wmask);
  wire [7:0] cfg_new  = merge_bits(cfg_rd, i_wdata, i_wmask);
  wire [7:0] dir_new  = merge_bits(dir_rd, i_wdata, i_wmask);

  // reset images at full byte width, cut to the stored bits on reset
  wire [7:0] chan_rst = `RST_CHANNEL_SELECT;
  wire [7:0] cfg_rst  = `RST_PIN_CONFIG;
  wire [7:0] dir_rst  = `RST_PORT_DIRECTION;

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      channel_code_q <= chan_rst[`CHANNEL_CODE_MSB:0];
      pin_config_q   <= cfg_rst[`PIN_CONFIG_KEEP_MSB:0];
      direction_q    <= dir_rst[`DIR_MSB:0];
    end else begin
      if (wr_chan) begin
        channel_code_q <= chan_new[`CHANNEL_CODE_MSB:0];
      end
      if (wr_cfg) begin
        pin_config_q <= cfg_new[`PIN_CONFIG_KEEP_MSB:0];
      end
      if (wr_dir) begin
        direction_q <= dir_new[`DIR_MSB:0];
      end
    end
  end

  // ==========================================================
  // conversion engine
  wire       done_w;
  wire [9:0] sar_value_w;

  sar_engine u_sar (
    .i_sys_clk    (i_sys_clk),
    .i_reset      (i_reset),
    .i_run        (i_conversion_enable),
    .i_restart    (wr_chan),
    .i_cmp_ge     (i_cmp_ge),
    .o_trial_code (o_trial_code),
    .o_sampling   (o_sampling),
    .o_done       (done_w),
    .o_sar_value  (sar_value_w)
  );

  // ==========================================================
  // result registers
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_result_word      <= `RST_RESULT_WORD;
      o_result_high_byte <= `RST_RESULT_HIGH;
      o_conv_done        <= 1'b0;
    end else begin
      o_conv_done <= done_w;
      if (done_w) begin
        o_result_word <= {sar_value_w, 6'h00};
        o_result_high_byte <= sar_value_w[9:2];
      end
    end
  end

  // ==========================================================
  // read port
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      if (sel_res_lo) begin
        o_rdata <= o_result_word[7:0];
      end else if (sel_res_hi) begin
        o_rdata <= o_result_high_byte;
      end else if (sel_chan) begin
        o_rdata <= chan_rd;
      end else if (sel_cfg) begin
        o_rdata <= cfg_rd;
      end else if (sel_dir) begin
        o_rdata <= dir_rd;
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  // ==========================================================
  // pin function resolution
  wire [2:0] pin_code   = pin_config_q[`PIN_CODE_MSB:0];
  wire       code_bad   = pin_code > `LAST_VALID_PIN_CODE;
  wire       chan_bad   = channel_code_q > `LAST_VALID_CHANNEL;
  wire [5:0] digital_w  = digital_mask(pin_code);
  wire [5:0] analog_w   = ~digital_w & ~i_segment_function_select;
  wire [5:0] digital_p  = digital_w & ~i_segment_function_select;
  wire [5:0] chan_w     = channel_onehot(channel_code_q);

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_analog_mux_sel     <= 6'h00;
      o_analog_pins        <= 6'h00;
      o_port_out_en        <= 6'h00;
      o_port_in_en         <= 6'h00;
      o_segment_en         <= 6'h00;
      o_setting_prohibited <= 1'b0;
    end else begin
      o_segment_en     <= i_segment_function_select;
      o_analog_pins    <= analog_w & direction_q;
      o_analog_mux_sel <= chan_w & analog_w & direction_q;
      o_port_out_en    <= digital_p & ~direction_q;
      o_port_in_en     <= digital_p & direction_q;
      o_setting_prohibited <= code_bad || chan_bad ||
                              |(analog_w & ~direction_q);
    end
  end

endmodule
`default_nettype wire

// >>> sim/adc_pin_control_assertions.sv
// Purpose: port-level checks for adc_pin_control
// Assumes: one clock, synchronous active-high reset
// Notes:   attached by bind after the module
`timescale 1ns/1ps
`default_nettype none
`include "adc_pin_regs.vh"
module adc_pin_control_assertions (
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic [15:0] i_addr,
  input wire logic        i_port_sel,
  input wire logic        i_rd,
  input wire logic        i_wr,
  input wire logic        i_conversion_enable,
  input wire logic [5:0]  i_segment_function_select,
  input wire logic        o_wait,
  input wire logic [15:0] o_result_word,
  input wire logic [7:0]  o_result_high_byte,
  input wire logic        o_sampling,
  input wire logic        o_conv_done,
  input wire logic [5:0]  o_analog_mux_sel,
  input wire logic [5:0]  o_analog_pins,
  input wire logic [5:0]  o_port_out_en,
  input wire logic [5:0]  o_segment_en
);
  // ==========================================================
  // decoded accesses
  wire rd_res = i_rd && (i_addr == `ADDR_RESULT_LOW ||
                         i_addr == `ADDR_RESULT_HIGH);
  wire wr_ch  = i_wr && i_addr == `ADDR_CHANNEL_SELECT;
  wire wr_cfg = i_wr && i_addr == `ADDR_PIN_CONFIG && !i_port_sel;
  wire wr_dir = i_wr && !i_rd && i_addr == `ADDR_PIN_CONFIG && i_port_sel;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // ==========================================================
  // properties
  property p_wait_rd; rd_res |-> o_wait; endproperty
  a_wait_rd: assert property (p_wait_rd)
    else $error("no wait on result read");
  property p_wait_wr; (wr_ch || wr_cfg) |-> o_wait; endproperty
  a_wait_wr: assert property (p_wait_wr)
    else $error("no wait on select or config write");
  property p_dir_nowait; wr_dir |-> !o_wait; endproperty
  a_dir_nowait: assert property (p_dir_nowait)
    else $error("wait on direction write");
  property p_high_copy; o_result_high_byte == o_result_word[15:8]; endproperty
  a_high_copy: assert property (p_high_copy)
    else $error("high byte differs from word");
  property p_low_zero; o_result_word[5:0] == 6'h00; endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("result low bits not zero");
  property p_hold; !o_conv_done |-> $stable(o_result_word); endproperty
  a_hold: assert property (p_hold)
    else $error("result changed without done");
  property p_done; o_conv_done |=> !o_conv_done; endproperty
  a_done: assert property (p_done)
    else $error("done longer than one cycle");
  property p_seg;
    1'b1 |=> o_segment_en == $past(i_segment_function_select);
  endproperty
  a_seg: assert property (p_seg)
    else $error("segment enable wrong");
  property p_seg_wins; (o_segment_en & o_analog_pins) == 6'h00; endproperty
  a_seg_wins: assert property (p_seg_wins)
    else $error("segment pin also analog");
  property p_no_aout; (o_analog_pins & o_port_out_en) == 6'h00; endproperty
  a_no_aout: assert property (p_no_aout)
    else $error("analog pin with output buffer");
  property p_mux;
    $onehot0(o_analog_mux_sel) && (o_analog_mux_sel & ~o_analog_pins) == 0;
  endproperty
  a_mux: assert property (p_mux)
    else $error("converted pin not a single analog pin");
  property p_restart;
    wr_ch && i_conversion_enable |-> ##[1:2] o_sampling;
  endproperty
  a_restart: assert property (p_restart)
    else $error("no restart after channel write");
  c_done: cover property (o_conv_done);
  c_restart: cover property (wr_ch && i_conversion_enable);
  c_seg: cover property (o_segment_en != 6'h00);
endmodule
bind adc_pin_control adc_pin_control_assertions adc_pin_control_assertions_inst (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
  .i_port_sel(i_port_sel), .i_rd(i_rd), .i_wr(i_wr),
  .i_conversion_enable(i_conversion_enable),
  .i_segment_function_select(i_segment_function_select),
  .o_wait(o_wait), .o_result_word(o_result_word),
  .o_result_high_byte(o_result_high_byte), .o_sampling(o_sampling),
  .o_conv_done(o_conv_done), .o_analog_mux_sel(o_analog_mux_sel),
  .o_analog_pins(o_analog_pins), .o_port_out_en(o_port_out_en),
  .o_segment_en(o_segment_en));
`default_nettype wire

// >>> sim/adc_pin_control_test.sv
// Purpose: self-checking bench for adc_pin_control
// Assumes: comparator answers from the trial code and a target value
// Notes:   pin table loop first, reset and hand tests after it
`timescale 1ns/1ps
`default_nettype none
`include "adc_pin_regs.vh"
module adc_pin_control_test;
  logic        i_sys_clk = 1'b0, i_reset = 1'b1, i_rd = 1'b0, i_wr = 1'b0;
  logic        i_port_sel = 1'b0, en = 1'b0, o_conv_done, o_prohib;
  logic [15:0] i_addr = 16'h0000, o_result_word;
  logic [7:0]  i_wdata = 8'h00, i_wmask = 8'h00, o_rdata, o_result_high_byte;
  logic [9:0]  target = 10'h000, o_trial_code;
  logic [5:0]  seg = 6'h00, o_mux, o_ana, o_oen, o_ien, o_seg;
  int          fail_count = 0, checks_done = 0, cycles = 0;
  wire         cmp_ge = target >= o_trial_code;
  typedef struct packed {
    logic [2:0] code; logic [5:0] dir, sg; logic [2:0] ch;
    logic [5:0] ana, oen, ien, mux;
  } row_t;
  row_t rows [7] = '{
    '{3'd1, 6'h3F, 6'h00, 3'd1, 6'h3E, 6'h00, 6'h01, 6'h02},
    '{3'd2, 6'h3C, 6'h00, 3'd2, 6'h3C, 6'h03, 6'h00, 6'h04},
    '{3'd3, 6'h3F, 6'h00, 3'd5, 6'h38, 6'h00, 6'h07, 6'h20},
    '{3'd4, 6'h30, 6'h00, 3'd4, 6'h30, 6'h0F, 6'h00, 6'h10},
    '{3'd5, 6'h3F, 6'h01, 3'd5, 6'h20, 6'h00, 6'h1E, 6'h20},
    '{3'd5, 6'h2F, 6'h00, 3'd5, 6'h20, 6'h10, 6'h0F, 6'h20},
    '{3'd0, 6'h3F, 6'h0C, 3'd5, 6'h33, 6'h00, 6'h00, 6'h20}};
  adc_pin_control adc_pin_control_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_port_sel(i_port_sel), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata),
    .i_wmask(i_wmask), .i_conversion_enable(en), .i_cmp_ge(cmp_ge),
    .i_segment_function_select(seg), .o_rdata(o_rdata), .o_wait(),
    .o_result_word(o_result_word), .o_result_high_byte(o_result_high_byte),
    .o_trial_code(o_trial_code), .o_sampling(), .o_conv_done(o_conv_done),
    .o_analog_mux_sel(o_mux), .o_analog_pins(o_ana), .o_port_out_en(o_oen),
    .o_port_in_en(o_ien), .o_segment_en(o_seg),
    .o_setting_prohibited(o_prohib));
  always #5 i_sys_clk = ~i_sys_clk;
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic s,
                     input logic [7:0] d, input logic [7:0] m);
    i_addr = a;
    i_port_sel = s;
    i_wdata = d;
    i_wmask = m;
    i_wr = w;
    i_rd = !w;
    @(posedge i_sys_clk);
    #1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic s,
                       input logic [7:0] e);
    bus(1'b0, a, s, 8'h00, 8'h00);
    chk(o_rdata, e);
  endtask
  task automatic wait_done;
    int n = 0;
    while (o_conv_done !== 1'b1 && n < 100) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk(n < 100, 1'b1);
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge i_sys_clk);
    #1;
    i_reset = 1'b0;
    @(posedge i_sys_clk);
    #1;
    foreach (rows[i]) begin
      seg = rows[i].sg;
      bus(1'b1, `ADDR_CHANNEL_SELECT, 1'b0, {5'h00, rows[i].ch}, 8'hFF);
      bus(1'b1, `ADDR_PIN_CONFIG, 1'b0, {5'h00, rows[i].code}, 8'hFF);
      bus(1'b1, `ADDR_PORT_DIRECTION, 1'b1, {2'h3, rows[i].dir}, 8'hFF);
      chk(o_ana, rows[i].ana);
      chk(o_oen, rows[i].oen);
      chk(o_ien, rows[i].ien);
      chk(o_mux, rows[i].mux);
      chk(o_seg, rows[i].sg);
      chk(o_prohib, 1'b0);
    end
    seg = 6'h00;
    i_reset = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_reset = 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk(o_ana, 6'h3F);
    chk(o_mux, 6'h01);
    chk(o_result_word, 16'h0000);
    rdchk(`ADDR_RESULT_HIGH, 1'b0, 8'h00);
    rdchk(`ADDR_CHANNEL_SELECT, 1'b0, 8'h00);
    rdchk(`ADDR_PIN_CONFIG, 1'b0, 8'h08);
    rdchk(`ADDR_PORT_DIRECTION, 1'b1, 8'hFF);
    bus(1'b1, `ADDR_PORT_DIRECTION, 1'b1, 8'h00, 8'h01);
    rdchk(`ADDR_PORT_DIRECTION, 1'b1, 8'hFE);
    bus(1'b1, `ADDR_PORT_DIRECTION, 1'b1, 8'h00, 8'hFF);
    rdchk(`ADDR_PORT_DIRECTION, 1'b1, 8'hC0);
    chk(o_prohib, 1'b1);
    bus(1'b1, `ADDR_PORT_DIRECTION, 1'b1, 8'hFF, 8'hFF);
    bus(1'b1, `ADDR_CHANNEL_SELECT, 1'b0, 8'h04, 8'h04);
    rdchk(`ADDR_CHANNEL_SELECT, 1'b0, 8'h04);
    bus(1'b1, `ADDR_CHANNEL_SELECT, 1'b0, 8'h07, 8'hFF);
    chk(o_prohib, 1'b1);
    bus(1'b1, `ADDR_PIN_CONFIG, 1'b0, 8'h06, 8'hFF);
    chk(o_ana, 6'h00);
    chk(o_ien, 6'h3F);
    bus(1'b1, `ADDR_PIN_CONFIG, 1'b0, 8'h07, 8'hFF);
    chk(o_ana, 6'h00);
    bus(1'b1, `ADDR_PIN_CONFIG, 1'b0, 8'h00, 8'hFF);
    bus(1'b1, `ADDR_RESULT_HIGH, 1'b0, 8'h5A, 8'hFF);
    rdchk(`ADDR_RESULT_HIGH, 1'b0, 8'h00);
    bus(1'b1, `ADDR_CHANNEL_SELECT, 1'b0, 8'h02, 8'hFF);
    target = 10'h2B5;
    en = 1'b1;
    wait_done();
    chk(o_result_word, 16'hAD40);
    chk(o_result_high_byte, 8'hAD);
    rdchk(`ADDR_RESULT_LOW, 1'b0, 8'h40);
    // abort lands inside the trial phase of the next conversion
    repeat (22) @(posedge i_sys_clk);
    #1;
    target = 10'h0FF;
    bus(1'b1, `ADDR_CHANNEL_SELECT, 1'b0, 8'h03, 8'hFF);
    wait_done();
    chk(o_result_word, 16'h3FC0);
    en = 1'b0;
    target = 10'h001;
    repeat (60) @(posedge i_sys_clk);
    #1;
    chk(o_result_word, 16'h3FC0);
    wrap_up();
  end
endmodule
`default_nettype wire
